//--- jdsr_pkg.sv
// Purpose: Constants for the scan-path, mailbox and reset logic.
// Assumes: Four-bit instruction register, shifted least significant first.
// Notes:   Used by jdsr_top, its checks and its bench, always with package-qualified names.

package jdsr_pkg;

	localparam int IR_W = 4;
	localparam int PIN_N = 8;
	localparam int BSC_W = 2 * PIN_N;
	localparam int ID_W = 32;
	localparam int MBX_W = 9;
	localparam int REV_W = 4;
	localparam int PART_W = 16;
	localparam int MANUF_W = 11;

	localparam logic [IR_W-1:0] OP_EXTEST = 4'h0;
	localparam logic [IR_W-1:0] OP_IDCODE = 4'h1;
	localparam logic [IR_W-1:0] OP_SAMPLE = 4'h2;
	localparam logic [IR_W-1:0] OP_DEBUG_A = 4'h8;
	localparam logic [IR_W-1:0] OP_DEBUG_B = 4'h9;
	localparam logic [IR_W-1:0] OP_DEBUG_C = 4'hA;
	localparam logic [IR_W-1:0] OP_DEBUG_D = 4'hB;
	localparam logic [IR_W-1:0] OP_RESET_CHIP = 4'hC;
	localparam logic [IR_W-1:0] OP_BYPASS = 4'hF;
	localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

	localparam int MBX_CLR_BIT = 8;
	localparam int BSC_DATA_OFS = 0;
	localparam int BSC_CTRL_OFS = 1;

	localparam logic [15:0] STARTUP_SHORT_CYC = 16'h0010;
	localparam logic [15:0] STARTUP_MID_CYC = 16'h0100;

endpackage

//--- jdsr_top.sv
// Purpose: Scan data registers, debug mailbox and test-reset control.
// Assumes: An outside state machine supplies TAP state strobes on tck.
// Notes:   Pin drivers run on core_clk; the scan path runs on tck alone.

`timescale 1ns/1ps

module jdsr_top #(
	parameter logic [3:0] ID_REVISION = 4'h0,
	parameter logic [15:0] ID_PART = 16'h0_123,
	parameter logic [10:0] ID_MANUF = 11'h0_55,
	parameter logic [15:0] STARTUP_LONG_CYC = 16'h4_000
) (
	input  wire logic                      core_clk,
	input  wire logic                      rst,
	input  wire logic                      tck,
	input  wire logic                      tdi,
	input  wire logic                      tap_reset,
	input  wire logic                      capture_ir,
	input  wire logic                      shift_ir,
	input  wire logic                      update_ir,
	input  wire logic                      capture_dr,
	input  wire logic                      shift_dr,
	input  wire logic                      update_dr,
	output logic                           tdo,
	output logic                           tdo_oe_n,
	output logic                           tap_enabled,
	output logic                           chip_reset_now,
	input  wire logic                      port_enable_fuse,
	input  wire logic                      debug_enable_fuse,
	input  wire logic                      jtag_disable_bit,
	input  wire logic                      protection_lock_one,
	input  wire logic                      protection_lock_two,
	input  wire logic                      chip_erase_done,
	input  wire logic                      debug_fuse_prog_req,
	output logic                           debug_fuse_prog_grant,
	input  wire logic [1:0]                startup_sel,
	output logic                           chip_in_reset,
	input  wire logic                      cpu_wr,
	input  wire logic                      cpu_rd,
	input  wire logic [7:0]                cpu_wdata,
	output logic [7:0]                     cpu_rdata,
	output logic                           ordinary_sel,
	input  wire logic [jdsr_pkg::PIN_N-1:0] core_pin_out,
	input  wire logic [jdsr_pkg::PIN_N-1:0] core_pin_oe,
	input  wire logic [jdsr_pkg::PIN_N-1:0] pin_in,
	output logic [jdsr_pkg::PIN_N-1:0]     pin_out,
	output logic [jdsr_pkg::PIN_N-1:0]     pin_oe_n
);

	// ****************************************************************
	// Test clock domain: enable and instruction register
	// ****************************************************************

	logic                               fuse_m_reg;
	logic                               fuse_s_reg;
	logic                               jdis_m_reg;
	logic                               jdis_s_reg;
	logic                               tap_en_reg;
	logic [jdsr_pkg::IR_W-1:0]          ir_sh_reg;
	logic [jdsr_pkg::IR_W-1:0]          ir_reg;
	logic                               byp_reg;
	logic [jdsr_pkg::ID_W-1:0]          id_sh_reg;
	logic                               rst_dr_reg;
	logic [jdsr_pkg::MBX_W-1:0]         mbx_sh_reg;
	logic                               dbgctl_sh_reg;
	logic                               acc_en_reg;
	logic                               dbgcd_reg;
	logic                               clr_tgl_reg;
	logic [jdsr_pkg::BSC_W-1:0]         bsc_sh_reg;
	logic [jdsr_pkg::BSC_W-1:0]         bsc_lat_reg;
	logic [jdsr_pkg::PIN_N-1:0]         pin_m_reg;
	logic [jdsr_pkg::PIN_N-1:0]         pin_s_reg;
	logic [jdsr_pkg::PIN_N-1:0]         oe_m_reg;
	logic [jdsr_pkg::PIN_N-1:0]         oe_s_reg;
	logic                               dirty_m_reg;
	logic                               dirty_s_reg;
	logic [7:0]                         mbx_m_reg;
	logic [7:0]                         mbx_s_reg;
	logic                               tdo_reg;
	logic                               tdo_oe_n_reg;
	logic [7:0]                         mbx_reg;
	logic                               dirty_reg;

	wire tap_en_next = fuse_s_reg & ~jdis_s_reg;
	wire tlr = tap_reset | ~tap_en_reg;
	wire cap_ir = capture_ir & tap_en_reg;
	wire sh_ir = shift_ir & tap_en_reg;
	wire upd_ir = update_ir & tap_en_reg;
	wire cap_dr = capture_dr & tap_en_reg;
	wire sh_dr = shift_dr & tap_en_reg;
	wire upd_dr = update_dr & tap_en_reg;

	// Opcode decode; anything unassigned falls to bypass.
	wire sel_ext = (ir_reg == jdsr_pkg::OP_EXTEST);
	wire sel_smp = (ir_reg == jdsr_pkg::OP_SAMPLE);
	wire sel_bsc = sel_ext | sel_smp;
	wire sel_id = (ir_reg == jdsr_pkg::OP_IDCODE);
	wire sel_rst = (ir_reg == jdsr_pkg::OP_RESET_CHIP);
	wire sel_mbx = (ir_reg == jdsr_pkg::OP_DEBUG_A);
	wire sel_dctl = (ir_reg == jdsr_pkg::OP_DEBUG_B);
	wire sel_dcd = (ir_reg == jdsr_pkg::OP_DEBUG_C) |
		(ir_reg == jdsr_pkg::OP_DEBUG_D);
	wire sel_byp = ~(sel_bsc | sel_id | sel_rst | sel_mbx |
		sel_dctl | sel_dcd);

	// Identification word: revision, part, manufacturer, then a fixed one.
	wire [jdsr_pkg::ID_W-1:0] id_word =
		{ID_REVISION, ID_PART, ID_MANUF, 1'b1};

	// Capture word per chain: data bit from the pad, control from the core.
	logic [jdsr_pkg::BSC_W-1:0] bsc_cap;
	always_comb
	begin
		bsc_cap = '0;
		for (int i = 0; i < jdsr_pkg::PIN_N; i++)
		begin
			bsc_cap[2*i + jdsr_pkg::BSC_DATA_OFS] = pin_s_reg[i];
			bsc_cap[2*i + jdsr_pkg::BSC_CTRL_OFS] = oe_s_reg[i];
		end
	end

	// The IR path is picked from capture on, so its first bit leads.
	wire tdo_next = (cap_ir | sh_ir) ? ir_sh_reg[0] :
		sel_bsc ? bsc_sh_reg[0] :
		sel_id ? id_sh_reg[0] :
		sel_rst ? rst_dr_reg :
		sel_mbx ? mbx_sh_reg[0] :
		sel_dctl ? dbgctl_sh_reg :
		sel_dcd ? dbgcd_reg : byp_reg;

	always_ff @(posedge tck or posedge rst)
	begin
		if (rst)
		begin
			fuse_m_reg <= 1'b0;
			fuse_s_reg <= 1'b0;
			jdis_m_reg <= 1'b0;
			jdis_s_reg <= 1'b0;
			tap_en_reg <= 1'b0;
		end
		else
		begin
			fuse_m_reg <= port_enable_fuse;
			fuse_s_reg <= fuse_m_reg;
			jdis_m_reg <= jtag_disable_bit;
			jdis_s_reg <= jdis_m_reg;
			tap_en_reg <= tap_en_next;
		end
	end

	// The instruction falls back to identification on any TAP reset.
	always_ff @(posedge tck or posedge rst)
	begin
		if (rst)
		begin
			ir_sh_reg <= jdsr_pkg::IR_CAPTURE;
			ir_reg <= jdsr_pkg::OP_IDCODE;
		end
		else if (tlr)
		begin
			ir_sh_reg <= jdsr_pkg::IR_CAPTURE;
			ir_reg <= jdsr_pkg::OP_IDCODE;
		end
		else
		begin
			if (cap_ir)
				ir_sh_reg <= jdsr_pkg::IR_CAPTURE;
			else if (sh_ir)
				ir_sh_reg <= {tdi, ir_sh_reg[jdsr_pkg::IR_W-1:1]};
			if (upd_ir)
				ir_reg <= ir_sh_reg;
		end
	end

	// ****************************************************************
	// Test clock domain: data registers
	// ****************************************************************

	always_ff @(posedge tck or posedge rst)
	begin
		if (rst)
		begin
			byp_reg <= 1'b0;
			id_sh_reg <= '0;
			dbgcd_reg <= 1'b0;
		end
		else
		begin
			if (cap_dr & sel_byp)
				byp_reg <= 1'b0;
			else if (sh_dr & sel_byp)
				byp_reg <= tdi;
			if (cap_dr & sel_id)
				id_sh_reg <= id_word;
			else if (sh_dr & sel_id)
				id_sh_reg <= {tdi, id_sh_reg[jdsr_pkg::ID_W-1:1]};
			if (cap_dr & sel_dcd)
				dbgcd_reg <= 1'b0;
			else if (sh_dr & sel_dcd)
				dbgcd_reg <= tdi;
		end
	end

	// The reset bit drives the chip reset straight from the shift stage,
	// so reset takes hold mid-shift; a TAP reset does not clear it.
	always_ff @(posedge tck or posedge rst)
	begin
		if (rst)
			rst_dr_reg <= 1'b0;
		else if (sh_dr & sel_rst)
			rst_dr_reg <= tdi;
	end

	// Mailbox path: capture byte and dirty, update may ask for a clear.
	always_ff @(posedge tck or posedge rst)
	begin
		if (rst)
		begin
			mbx_sh_reg <= '0;
			clr_tgl_reg <= 1'b0;
			dbgctl_sh_reg <= 1'b0;
			acc_en_reg <= 1'b0;
		end
		else
		begin
			if (cap_dr & sel_mbx)
				mbx_sh_reg <= {dirty_s_reg, mbx_s_reg};
			else if (sh_dr & sel_mbx)
				mbx_sh_reg <= {tdi, mbx_sh_reg[jdsr_pkg::MBX_W-1:1]};
			if (upd_dr & sel_mbx & mbx_sh_reg[jdsr_pkg::MBX_CLR_BIT])
				clr_tgl_reg <= ~clr_tgl_reg;
			if (cap_dr & sel_dctl)
				dbgctl_sh_reg <= acc_en_reg;
			else if (sh_dr & sel_dctl)
				dbgctl_sh_reg <= tdi;
			if (tlr)
				acc_en_reg <= 1'b0;
			else if (upd_dr & sel_dctl)
				acc_en_reg <= dbgctl_sh_reg;
		end
	end

	// Boundary chain; runs on tck alone, so the core clock may be stopped.
	always_ff @(posedge tck or posedge rst)
	begin
		if (rst)
		begin
			pin_m_reg <= '0;
			pin_s_reg <= '0;
			oe_m_reg <= '0;
			oe_s_reg <= '0;
			dirty_m_reg <= 1'b0;
			dirty_s_reg <= 1'b0;
			mbx_m_reg <= '0;
			mbx_s_reg <= '0;
			bsc_sh_reg <= '0;
			bsc_lat_reg <= '0;
		end
		else
		begin
			pin_m_reg <= pin_in;
			pin_s_reg <= pin_m_reg;
			oe_m_reg <= core_pin_oe;
			oe_s_reg <= oe_m_reg;
			dirty_m_reg <= dirty_reg;
			dirty_s_reg <= dirty_m_reg;
			mbx_m_reg <= mbx_reg;
			mbx_s_reg <= mbx_m_reg;
			if (cap_dr & sel_bsc)
				bsc_sh_reg <= bsc_cap;
			else if (sh_dr & sel_bsc)
				bsc_sh_reg <= {tdi, bsc_sh_reg[jdsr_pkg::BSC_W-1:1]};
			if (upd_dr & sel_bsc)
				bsc_lat_reg <= bsc_sh_reg;
		end
	end

	// Output changes on the falling edge so the tester samples it stable.
	always_ff @(negedge tck or posedge rst)
	begin
		if (rst)
		begin
			tdo_reg <= 1'b0;
			tdo_oe_n_reg <= 1'b1;
		end
		else
		begin
			tdo_reg <= tdo_next;
			tdo_oe_n_reg <= ~(cap_ir | sh_ir | cap_dr | sh_dr);
		end
	end

	assign tdo = tdo_reg;
	assign tdo_oe_n = tdo_oe_n_reg;
	assign tap_enabled = tap_en_reg;
	assign chip_reset_now = rst_dr_reg;

	// ****************************************************************
	// Core clock domain: crossings, mailbox and programming gate
	// ****************************************************************

	logic                       ext_m_reg;
	logic                       ext_s_reg;
	logic [jdsr_pkg::BSC_W-1:0] lat_m_reg;
	logic [jdsr_pkg::BSC_W-1:0] lat_s_reg;
	logic                       rdr_m_reg;
	logic                       rdr_s_reg;
	logic                       acc_m_reg;
	logic                       acc_s_reg;
	logic                       ocd_m_reg;
	logic                       ocd_s_reg;
	logic [2:0]                 clr_sync_reg;
	logic [7:0]                 cpu_rdata_reg;
	logic                       ordinary_reg;
	logic                       erased_reg;
	logic                       grant_reg;
	logic [15:0]                hold_cnt_reg;
	logic                       in_reset_reg;
	logic [jdsr_pkg::PIN_N-1:0] pin_out_reg;
	logic [jdsr_pkg::PIN_N-1:0] pin_oe_n_reg;

	wire clr_evt = clr_sync_reg[2] ^ clr_sync_reg[1];
	wire mbx_route = ocd_s_reg & acc_s_reg;
	// Accesses follow the registered route so they agree with ordinary_sel.
	wire mbx_wr = cpu_wr & ~ordinary_reg;
	wire mbx_rd = cpu_rd & ~ordinary_reg;
	wire locked = protection_lock_one | protection_lock_two;
	wire grant_next = debug_fuse_prog_req & (~locked | erased_reg);
	wire [15:0] startup_cyc = (startup_sel == 2'd0) ? 16'h0_000 :
		(startup_sel == 2'd1) ? jdsr_pkg::STARTUP_SHORT_CYC :
		(startup_sel == 2'd2) ? jdsr_pkg::STARTUP_MID_CYC :
		STARTUP_LONG_CYC;

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			ext_m_reg <= 1'b0;
			ext_s_reg <= 1'b0;
			lat_m_reg <= '0;
			lat_s_reg <= '0;
			rdr_m_reg <= 1'b0;
			rdr_s_reg <= 1'b0;
			acc_m_reg <= 1'b0;
			acc_s_reg <= 1'b0;
			ocd_m_reg <= 1'b0;
			ocd_s_reg <= 1'b0;
			clr_sync_reg <= '0;
		end
		else
		begin
			ext_m_reg <= sel_ext & tap_en_reg;
			ext_s_reg <= ext_m_reg;
			lat_m_reg <= bsc_lat_reg;
			lat_s_reg <= lat_m_reg;
			rdr_m_reg <= rst_dr_reg;
			rdr_s_reg <= rdr_m_reg;
			acc_m_reg <= acc_en_reg;
			acc_s_reg <= acc_m_reg;
			ocd_m_reg <= debug_enable_fuse;
			ocd_s_reg <= ocd_m_reg;
			clr_sync_reg <= {clr_sync_reg[1:0], clr_tgl_reg};
		end
	end

	// A CPU write in the same cycle as a debugger clear keeps the flag set.
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			mbx_reg <= '0;
			dirty_reg <= 1'b0;
			cpu_rdata_reg <= '0;
			ordinary_reg <= 1'b1;
		end
		else
		begin
			if (mbx_wr)
				mbx_reg <= cpu_wdata;
			if (mbx_wr)
				dirty_reg <= 1'b1;
			else if (clr_evt)
				dirty_reg <= 1'b0;
			if (mbx_rd)
				cpu_rdata_reg <= {dirty_reg, mbx_reg[6:0]};
			ordinary_reg <= ~mbx_route;
		end
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			erased_reg <= 1'b0;
			grant_reg <= 1'b0;
		end
		else
		begin
			if (chip_erase_done)
				erased_reg <= 1'b1;
			grant_reg <= grant_next;
		end
	end

	// Reset stays asserted while the bit is one, then counts the time-out.
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			hold_cnt_reg <= '0;
			in_reset_reg <= 1'b1;
		end
		else if (rdr_s_reg)
		begin
			hold_cnt_reg <= startup_cyc;
			in_reset_reg <= 1'b1;
		end
		else if (hold_cnt_reg != 16'h0_000)
		begin
			hold_cnt_reg <= hold_cnt_reg - 16'h0_001;
			in_reset_reg <= 1'b1;
		end
		else
			in_reset_reg <= 1'b0;
	end

	// ****************************************************************
	// Pin drivers
	// ****************************************************************

	logic [jdsr_pkg::PIN_N-1:0] lat_data;
	logic [jdsr_pkg::PIN_N-1:0] lat_ctrl;
	always_comb
	begin
		lat_data = '0;
		lat_ctrl = '0;
		for (int i = 0; i < jdsr_pkg::PIN_N; i++)
		begin
			lat_data[i] = lat_s_reg[2*i + jdsr_pkg::BSC_DATA_OFS];
			lat_ctrl[i] = lat_s_reg[2*i + jdsr_pkg::BSC_CTRL_OFS];
		end
	end

	// Reset wins over pin-test so a held reset floats the board quietly.
	wire float_all = in_reset_reg | rdr_s_reg;

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			pin_out_reg <= '0;
			pin_oe_n_reg <= '1;
		end
		else if (float_all)
		begin
			pin_out_reg <= '0;
			pin_oe_n_reg <= '1;
		end
		else if (ext_s_reg)
		begin
			pin_out_reg <= lat_data;
			pin_oe_n_reg <= ~lat_ctrl;
		end
		else
		begin
			pin_out_reg <= core_pin_out;
			pin_oe_n_reg <= ~core_pin_oe;
		end
	end

	assign pin_out = pin_out_reg;
	assign pin_oe_n = pin_oe_n_reg;
	assign cpu_rdata = cpu_rdata_reg;
	assign ordinary_sel = ordinary_reg;
	assign debug_fuse_prog_grant = grant_reg;
	assign chip_in_reset = in_reset_reg;

endmodule // jdsr_top

//--- jdsr_scan_host.sv
// Purpose: Behavioural scan controller that frames tck and the strobes.
// Assumes: Strobes change 1 ns after a tck fall; tdo is taken on the rise.
// Notes:   tck stands low between frames; tdi inverts once released.

`timescale 1ns/1ps

module jdsr_scan_host (
	output logic      tck,
	output logic      tdi,
	output logic      tap_reset,
	output logic      capture_ir,
	output logic      shift_ir,
	output logic      update_ir,
	output logic      capture_dr,
	output logic      shift_dr,
	output logic      update_dr,
	input  wire logic tdo
);
	initial
	begin
		{tck, tdi, tap_reset} = 3'h0;
		{capture_ir, shift_ir, update_ir} = 3'h0;
		{capture_dr, shift_dr, update_dr} = 3'h0;
	end

	// One 32 ns period; tdo was launched on the fall before this rise.
	task automatic tick(output logic s);
		#15 tck = 1'b1;
		s = tdo;
		#16 tck = 1'b0;
		#1;
	endtask

	task automatic idle(input int n);
		logic b;
		repeat (n) tick(b);
	endtask

	task automatic reset_tap;
		logic b;
		tap_reset = 1'b1;
		tick(b);
		tap_reset = 1'b0;
	endtask

	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		logic b;
		dout = 32'h0000_0000;
		capture_ir = ir;
		capture_dr = ~ir;
		tick(b);
		{capture_ir, capture_dr} = 2'h0;
		shift_ir = ir;
		shift_dr = ~ir;
		for (int i = 0; i < n; i++)
		begin
			tdi = din[i];
			tick(b);
			dout[i] = b;
		end
		{shift_ir, shift_dr} = 2'h0;
		update_ir = ir;
		update_dr = ~ir;
		tick(b);
		{update_ir, update_dr} = 2'h0;
		// A released line must not keep showing the last bit.
		tdi = ~tdi;
	endtask
endmodule // jdsr_scan_host

//--- jdsr_top_asserts.sv
// Purpose: Concurrent checks on the scan, mailbox and reset ports.
// Assumes: Scan strobes change away from the tck rise.
// Notes:   Bound into every jdsr_top instance.

`timescale 1ns/1ps

module jdsr_top_asserts (
	input wire logic                        core_clk,
	input wire logic                        rst,
	input wire logic                        tck,
	input wire logic                        shift_ir,
	input wire logic                        shift_dr,
	input wire logic                        tdo_oe_n,
	input wire logic                        tap_enabled,
	input wire logic                        chip_reset_now,
	input wire logic                        port_enable_fuse,
	input wire logic                        debug_enable_fuse,
	input wire logic                        jtag_disable_bit,
	input wire logic                        protection_lock_one,
	input wire logic                        protection_lock_two,
	input wire logic                        debug_fuse_prog_req,
	input wire logic                        debug_fuse_prog_grant,
	input wire logic [1:0]                  startup_sel,
	input wire logic                        chip_in_reset,
	input wire logic                        cpu_wr,
	input wire logic                        cpu_rd,
	input wire logic [7:0]                  cpu_wdata,
	input wire logic [7:0]                  cpu_rdata,
	input wire logic                        ordinary_sel,
	input wire logic [jdsr_pkg::PIN_N-1:0]  pin_oe_n
);
	sequence s_write_read;
		cpu_wr && !ordinary_sel ##1 cpu_rd && !ordinary_sel;
	endsequence

	sequence s_reset_release;
		$fell(chip_reset_now) && startup_sel == 2'h2;
	endsequence

	a_write_then_read: assert property (
		@(posedge core_clk) disable iff (rst) s_write_read |=>
		cpu_rdata == ($past(cpu_wdata, 2) | 8'h80)) else $error("bad read");
	a_rdata_stands: assert property (
		@(posedge core_clk) disable iff (rst) !(cpu_rd && !ordinary_sel)
		|=> $stable(cpu_rdata)) else $error("read data moved");
	a_route_fuse_off: assert property (
		@(posedge core_clk) disable iff (rst)
		!debug_enable_fuse [*4] |-> ordinary_sel) else $error("bad route");
	a_reset_reaches_core: assert property (
		@(posedge core_clk) disable iff (rst)
		chip_reset_now [*4] |-> chip_in_reset) else $error("no reset");
	a_reset_floats_pins: assert property (
		@(posedge core_clk) disable iff (rst)
		chip_in_reset |=> &pin_oe_n) else $error("pins driven in reset");
	a_startup_hold: assert property (
		@(posedge core_clk) disable iff (rst)
		s_reset_release |-> chip_in_reset [*8]) else $error("short hold");
	a_grant_free: assert property (
		@(posedge core_clk) disable iff (rst) debug_fuse_prog_req &&
		!protection_lock_one && !protection_lock_two
		|=> debug_fuse_prog_grant) else $error("grant missing");
	a_grant_needs_req: assert property (
		@(posedge core_clk) disable iff (rst)
		!debug_fuse_prog_req |=> !debug_fuse_prog_grant) else $error("grant");
	a_port_gate: assert property (
		@(posedge tck) disable iff (rst)
		(jtag_disable_bit || !port_enable_fuse) [*4] |-> !tap_enabled)
		else $error("port left enabled");
	a_shift_drives_tdo: assert property (
		@(posedge tck) disable iff (rst) (shift_ir || shift_dr) &&
		tap_enabled |=> !tdo_oe_n) else $error("tdo not driven");
	a_reset_reg_steady: assert property (
		@(posedge tck) disable iff (rst)
		!shift_dr |=> $stable(chip_reset_now)) else $error("reset bit moved");
endmodule // jdsr_top_asserts

bind jdsr_top jdsr_top_asserts i_jdsr_top_asserts (.core_clk, .rst, .tck,
	.shift_ir, .shift_dr, .tdo_oe_n, .tap_enabled, .chip_reset_now,
	.port_enable_fuse, .debug_enable_fuse, .jtag_disable_bit,
	.protection_lock_one, .protection_lock_two, .debug_fuse_prog_req,
	.debug_fuse_prog_grant, .startup_sel, .chip_in_reset, .cpu_wr, .cpu_rd,
	.cpu_wdata, .cpu_rdata, .ordinary_sel, .pin_oe_n);

//--- jdsr_top_bench.sv
// Purpose: Self-checking bench for jdsr_top.
// Assumes: jdsr_scan_host frames tck; core inputs move on core_clk.
// Notes:   Start-up select 2 keeps the release window easy to see.

`timescale 1ns/1ps

module jdsr_top_bench;
	localparam logic [3:0]  ID_REV   = 4'h1;     // Arbitrary value.
	localparam logic [15:0] ID_PART  = 16'h3c5a; // Arbitrary value.
	localparam logic [10:0] ID_MANUF = 11'h2a5;  // Arbitrary value.
	localparam logic [31:0] ID_WORD  = {ID_REV, ID_PART, ID_MANUF, 1'b1};

	logic       clk_raw, core_run, core_clk, rst, tck, tdi, tap_reset, tdo;
	logic       capture_ir, shift_ir, update_ir, capture_dr, shift_dr;
	logic       update_dr, tdo_oe_n, tap_enabled, chip_reset_now;
	logic       port_enable_fuse, debug_enable_fuse, jtag_disable_bit;
	logic       protection_lock_one, protection_lock_two, chip_erase_done;
	logic       debug_fuse_prog_req, debug_fuse_prog_grant, cpu_wr, cpu_rd;
	logic       chip_in_reset, ordinary_sel;
	logic [1:0] startup_sel;
	logic [7:0] cpu_wdata, cpu_rdata, core_pin_out, core_pin_oe;
	logic [7:0] pin_in, pin_out, pin_oe_n;
	int         fail_count, checks;

	jdsr_top #(.ID_REVISION(ID_REV), .ID_PART(ID_PART), .ID_MANUF(ID_MANUF),
		.STARTUP_LONG_CYC(16'h0020)) i_jdsr_top (.core_clk, .rst, .tck,
		.tdi, .tap_reset, .capture_ir, .shift_ir, .update_ir, .capture_dr,
		.shift_dr, .update_dr, .tdo, .tdo_oe_n, .tap_enabled, .chip_reset_now,
		.port_enable_fuse, .debug_enable_fuse, .jtag_disable_bit,
		.protection_lock_one, .protection_lock_two, .chip_erase_done,
		.debug_fuse_prog_req, .debug_fuse_prog_grant, .startup_sel,
		.chip_in_reset, .cpu_wr, .cpu_rd, .cpu_wdata, .cpu_rdata,
		.ordinary_sel, .core_pin_out, .core_pin_oe, .pin_in, .pin_out,
		.pin_oe_n);

	jdsr_scan_host i_jdsr_scan_host (.tck, .tdi, .tap_reset, .capture_ir,
		.shift_ir, .update_ir, .capture_dr, .shift_dr, .update_dr, .tdo);

	// Gating lets a scan run with the system clock stopped.
	assign core_clk = clk_raw & core_run;

	initial
	begin
		clk_raw = 1'b0;
		forever #2 clk_raw = ~clk_raw;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish;
		if (fail_count == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic wait_core(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic dr(input int n, input logic [31:0] din,
		output logic [31:0] d);
		i_jdsr_scan_host.scan(1'b0, n, din, d);
	endtask

	task automatic load_ir(input logic [3:0] op);
		logic [31:0] d;
		i_jdsr_scan_host.scan(1'b1, 4, {28'h000_0000, op}, d);
		check(d, 32'h0000_0001);
	endtask

	task automatic t_idcode;
		logic [31:0] d;
		dr(32, 32'h0000_0000, d);
		check(d, ID_WORD);
		@(negedge clk_raw);
		core_run = 1'b0;
		dr(32, 32'h0000_0000, d);
		check(d, ID_WORD);
		@(negedge clk_raw);
		core_run = 1'b1;
	endtask

	task automatic t_bypass;
		logic [31:0] d;
		logic [3:0]  ops [4] = '{jdsr_pkg::OP_BYPASS, 4'h5,
			jdsr_pkg::OP_DEBUG_C, jdsr_pkg::OP_DEBUG_D};
		foreach (ops[k])
		begin
			load_ir(ops[k]);
			dr(3, 32'h0000_0003, d);
			check(d, 32'h0000_0006);
		end
		i_jdsr_scan_host.reset_tap();
		dr(32, 32'h0000_0000, d);
		check(d, ID_WORD);
	endtask

	task automatic t_mailbox;
		logic [31:0] d;
		check(ordinary_sel, 1'b1);
		load_ir(jdsr_pkg::OP_DEBUG_B);
		dr(1, 32'h0000_0001, d);
		wait_core(4);
		check(ordinary_sel, 1'b0);
		@(posedge core_clk);
		cpu_wdata <= 8'h35;
		cpu_wr <= 1'b1;
		@(posedge core_clk);
		cpu_wr <= 1'b0;
		cpu_rd <= 1'b1;
		@(posedge core_clk);
		cpu_rd <= 1'b0;
		wait_core(1);
		check(cpu_rdata, 8'hb5);
		load_ir(jdsr_pkg::OP_DEBUG_A);
		dr(9, 32'h0000_0100, d);
		check(d, 32'h0000_0135);
		wait_core(6);
		@(posedge core_clk);
		cpu_rd <= 1'b1;
		@(posedge core_clk);
		cpu_rd <= 1'b0;
		wait_core(1);
		check(cpu_rdata[7], 1'b0);
		@(posedge core_clk);
		debug_enable_fuse <= 1'b0;
		wait_core(5);
		check(ordinary_sel, 1'b1);
		@(posedge core_clk);
		debug_enable_fuse <= 1'b1;
	endtask

	task automatic t_reset_reg;
		logic [31:0] d;
		load_ir(jdsr_pkg::OP_RESET_CHIP);
		dr(1, 32'h0000_0001, d);
		check(chip_reset_now, 1'b1);
		wait_core(4);
		check(chip_in_reset, 1'b1);
		check(pin_oe_n, 8'hff);
		dr(1, 32'h0000_0000, d);
		wait_core(100);
		check(chip_in_reset, 1'b1);
		wait_core(200);
		check(chip_in_reset, 1'b0);
	endtask

	task automatic t_boundary;
		logic [31:0] d, pre, cap;
		logic [7:0]  pd, pc;
		pd = 8'hc3;
		pc = 8'hf0;
		pre = 32'h0000_0000;
		cap = 32'h0000_0000;
		for (int i = 0; i < 8; i++)
		begin
			pre[2*i] = pd[i];
			pre[2*i+1] = pc[i];
			cap[2*i] = pin_in[i];
			cap[2*i+1] = core_pin_oe[i];
		end
		load_ir(jdsr_pkg::OP_SAMPLE);
		dr(16, pre, d);
		check(d, cap);
		wait_core(4);
		check(pin_out, core_pin_out);
		check(pin_oe_n, 8'(~core_pin_oe));
		load_ir(jdsr_pkg::OP_EXTEST);
		wait_core(4);
		check(pin_out, 8'hc3);
		check(pin_oe_n, 8'h0f);
		load_ir(jdsr_pkg::OP_BYPASS);
	endtask

	task automatic t_disable;
		logic [31:0] d;
		@(posedge core_clk);
		jtag_disable_bit <= 1'b1;
		i_jdsr_scan_host.idle(4);
		check(tap_enabled, 1'b0);
		i_jdsr_scan_host.scan(1'b1, 4, 32'h0000_000f, d);
		@(posedge core_clk);
		jtag_disable_bit <= 1'b0;
		port_enable_fuse <= 1'b0;
		i_jdsr_scan_host.idle(4);
		check(tap_enabled, 1'b0);
		@(posedge core_clk);
		port_enable_fuse <= 1'b1;
		i_jdsr_scan_host.idle(4);
		check(tap_enabled, 1'b1);
		dr(32, 32'h0000_0000, d);
		check(d, ID_WORD);
	endtask

	task automatic t_grant;
		@(posedge core_clk);
		debug_fuse_prog_req <= 1'b1;
		wait_core(2);
		check(debug_fuse_prog_grant, 1'b1);
		@(posedge core_clk);
		protection_lock_one <= 1'b1;
		wait_core(2);
		check(debug_fuse_prog_grant, 1'b0);
		@(posedge core_clk);
		chip_erase_done <= 1'b1;
		@(posedge core_clk);
		chip_erase_done <= 1'b0;
		wait_core(2);
		check(debug_fuse_prog_grant, 1'b1);
	endtask

	initial
	begin
		#100_000;
		fail_count++;
		tally_and_finish();
	end

	initial
	begin
		rst = 1'b1;
		core_run = 1'b1;
		{port_enable_fuse, debug_enable_fuse, jtag_disable_bit} = 3'h6;
		{protection_lock_one, protection_lock_two, chip_erase_done} = 3'h0;
		{debug_fuse_prog_req, cpu_wr, cpu_rd} = 3'h0;
		startup_sel = 2'h2;
		cpu_wdata = 8'h00;
		core_pin_out = 8'h3c;
		core_pin_oe = 8'h0f;
		pin_in = 8'h96;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		i_jdsr_scan_host.idle(4);
		t_idcode();
		t_bypass();
		t_mailbox();
		t_reset_reg();
		t_boundary();
		t_disable();
		t_grant();
		tally_and_finish();
	end
endmodule // jdsr_top_bench
